// *** core/dram_mr_consts.vh ***
// Purpose: Shared constants for the mode-register slice
// Assumes: Included by the mode-register bank and its timer
// Notes:   Offsets are mode-register addresses on the 6-bit address field
`ifndef DRAM_MR_CONSTS_VH
`define DRAM_MR_CONSTS_VH

// Mode-register addresses
`define MA_UPPER_BYTE_CAL_INVERT 6'h14
`define MA_RESERVED_SLOT_A       6'h15
`define MA_TERMINATION_OVERRIDE  6'h16
`define MA_DQS_TIMER_RUN_TIME    6'h17

// Reset values
`define RST_UPPER_BYTE_CAL_INVERT 8'h00
`define RST_TERMINATION_OVERRIDE  8'h00
`define RST_DQS_TIMER_RUN_TIME    8'h00

// Termination override field positions
`define TO_CTRL_TERM_LSB   0
`define TO_CTRL_TERM_MSB   2
`define TO_CLOCK_TERM_N    3
`define TO_CHIP_SEL_TERM_N 4
`define TO_COMMAND_TERM_D  5
`define TO_BYTE_LO_DIS     6
`define TO_BYTE_HI_DIS     7

// Controller termination codes
`define CTRL_TERM_OFF      3'h0
`define CTRL_TERM_RESERVED 3'h7

// Run-time field decode and limits, in clocks
`define RT_STEP_SHIFT  4
`define RT_LIMIT_MID   16'h0800
`define RT_LIMIT_LONG  16'h1000
`define RT_TOP_MID     2'h1
`define RT_TOP_LONG    2'h2
`define RT_TOP_SHORT   2'h0

// Read answer for unreadable addresses
`define MRR_EMPTY 8'h00

`endif

// *** core/dqs_interval_timer.v ***
// Purpose: DQS interval timer with run-time controlled automatic stop
// Assumes: Timer clocks are i_clk cycles
// Notes:   Reserved top-bit code 11 behaves like the free-running setting
`timescale 1ns/100ps
`default_nettype none
`include "dram_mr_consts.vh"

module dqs_interval_timer (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	// Control
	input  wire        i_start,
	input  wire        i_stop,
	input  wire [7:0]  i_run_time,
	// Status
	output reg         o_running,
	output reg  [15:0] o_elapsed
);

	// Stop limit from the run-time code, zero meaning no automatic stop
	function [15:0] stop_limit;
		input [7:0] code;
		begin
			case (code[7:6])
				`RT_TOP_SHORT: stop_limit = {6'h00, code[5:0], 4'h0};
				`RT_TOP_MID:   stop_limit = `RT_LIMIT_MID;
				`RT_TOP_LONG:  stop_limit = `RT_LIMIT_LONG;
				default:       stop_limit = 16'h0000;
			endcase
		end
	endfunction

	wire [15:0] limit = stop_limit(i_run_time);
	wire        auto_off = (limit == 16'h0000);
	wire [15:0] next_elapsed = o_elapsed + 16'h0001;

	// Count from start until the limit, or with a zero limit until an explicit stop
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_running <= 1'b0;
			o_elapsed <= 16'h0000;
		end else if (i_start) begin
			o_running <= 1'b1;
			o_elapsed <= 16'h0000;
		end else if (o_running) begin
			o_elapsed <= next_elapsed;
			if (!auto_off && next_elapsed == limit) // RULE14
				o_running <= 1'b0;
			else if (auto_off && i_stop) // RULE15
				o_running <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** core/dram_mr_bank.v ***
// Purpose: Mode-register bank for calibration invert, termination
//          override with two set points, and DQS timer run time
// Assumes: Mode-register commands arrive as one-cycle strobes on i_clk
// Notes:   Reads answer one cycle after the strobe
//          Only the termination override reads back, from the
//          write set-point copy; other slots read as zero
//          Termination and inversion outputs are registered
// Functional notes
// (RULE1) Invert bits map to upper data lanes
// (RULE2) Upper mask lane never inverted
// (RULE3) No bus inversion during calibration output
// (RULE4) Controller termination code, zero disables
// (RULE5) Controller avoids codes 1,3,5,6 without I/O bit
// (RULE6) Bit 3 zero enables clock termination
// (RULE7) Bit 4 zero enables chip-select termination
// (RULE8) Bit 5 zero enables command termination
// (RULE9) Bits 6,7 disable termination per byte
// (RULE10) Access uses write set-point copy
// (RULE11) Operation uses operating set-point copy
// (RULE12) Dedicated termination pin is ignored
// (RULE13) Controller programs overrides before enabling termination
// (RULE14) Run-time code sets automatic timer stop
// (RULE15) Zero run time means explicit stop only
// (RULE16) Stop command legal only with zero run time
// (RULE17) Controller joins both oscillator count bytes
`timescale 1ns/100ps
`default_nettype none
`include "dram_mr_consts.vh"

module dram_mr_bank (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	// Mode-register command port
	input  wire        i_mr_write,
	input  wire        i_mr_read,
	input  wire [5:0]  i_mr_addr,
	input  wire [7:0]  i_mr_wdata,
	output reg  [7:0]  o_mr_rdata,
	output reg         o_mr_rvalid,
	// Set-point selects and other mode-register bits
	input  wire        i_write_set_point_select,
	input  wire        i_operating_set_point_select,
	input  wire        i_data_bus_inversion_en,
	input  wire        i_term_ctl_command_en,
	input  wire        i_term_ctl_chip_sel_en,
	input  wire        i_term_ctl_clock_en,
	input  wire        i_byte_mode,
	input  wire        i_non_terminating_rank,
	// Read calibration pattern path
	input  wire        i_cal_active,
	input  wire        i_cal_bit,
	output reg  [7:0]  o_cal_upper_dq,
	output reg         o_cal_upper_mask_lane,
	output wire        o_data_bus_inversion_active,
	// Termination controls in force
	output wire [2:0]  o_controller_termination_value,
	output wire [1:0]  o_clock_term_on,
	output wire [1:0]  o_chip_sel_term_on,
	output wire [1:0]  o_command_term_on,
	// DQS interval timer
	input  wire        i_timer_start,
	input  wire        i_timer_stop,
	output wire        o_timer_running,
	output wire [15:0] o_timer_elapsed
);

	// Register storage, one override copy per set point
	reg [7:0] upper_byte_cal_invert;
	reg [7:0] termination_override [0:1];
	reg [7:0] dqs_timer_run_time;

	// Address match for one mode-register slot
	function addr_hit;
		input [5:0] addr;
		input [5:0] slot;
		begin
			addr_hit = (addr == slot);
		end
	endfunction

	// Slot decodes for the write path; only hit_term is shared with the read path
	wire hit_invert = addr_hit(i_mr_addr, `MA_UPPER_BYTE_CAL_INVERT);
	wire hit_term   = addr_hit(i_mr_addr, `MA_TERMINATION_OVERRIDE);
	wire hit_timer  = addr_hit(i_mr_addr, `MA_DQS_TIMER_RUN_TIME);

	// Register writes; reserved slot takes nothing
	always @(posedge i_clk) begin
		if (i_rst) begin
			upper_byte_cal_invert   <= `RST_UPPER_BYTE_CAL_INVERT;
			termination_override[0] <= `RST_TERMINATION_OVERRIDE; // RULE4
			termination_override[1] <= `RST_TERMINATION_OVERRIDE;
			dqs_timer_run_time      <= `RST_DQS_TIMER_RUN_TIME;
		end else if (i_mr_write) begin
			if (hit_invert)
				upper_byte_cal_invert <= i_mr_wdata;
			if (hit_term)
				termination_override[i_write_set_point_select]
					<= i_mr_wdata; // RULE10
			if (hit_timer)
				dqs_timer_run_time <= i_mr_wdata;
		end
	end

	// Read data per slot; write-only and reserved slots read empty
	reg [7:0] next_mr_rdata;
	always @* begin
		next_mr_rdata = `MRR_EMPTY;
		if (hit_term)
			next_mr_rdata =
				termination_override[i_write_set_point_select]; // RULE10
	end

	// Read answer, one cycle after the strobe
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_mr_rdata  <= `MRR_EMPTY;
			o_mr_rvalid <= 1'b0;
		end else begin
			o_mr_rvalid <= i_mr_read;
			if (i_mr_read)
				o_mr_rdata <= next_mr_rdata;
		end
	end

	// Calibration pattern lanes, each inverted by its own bit
	wire [7:0] next_cal_upper_dq;
	genvar lane;
	generate
		for (lane = 0; lane < 8; lane = lane + 1) begin : g_lane
			assign next_cal_upper_dq[lane] =
				i_cal_bit ^ upper_byte_cal_invert[lane]; // RULE1
		end
	endgenerate

	// Lanes registered in one process; mask lane carries the true pattern
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_cal_upper_dq        <= 8'h00;
			o_cal_upper_mask_lane <= 1'b0;
		end else begin
			o_cal_upper_dq        <= next_cal_upper_dq; // RULE1
			o_cal_upper_mask_lane <= i_cal_bit; // RULE2
		end
	end

	// Active set-point copy drives termination; pin input not used
	wire [7:0] op_copy = // RULE12
		termination_override[i_operating_set_point_select]; // RULE11
	wire [2:0] ctrl_code = op_copy[`TO_CTRL_TERM_MSB:`TO_CTRL_TERM_LSB];
	wire [1:0] byte_dis  = i_byte_mode ?
		{op_copy[`TO_BYTE_HI_DIS], op_copy[`TO_BYTE_LO_DIS]} : 2'h0; // RULE9

	// Reserved code drives no termination
	wire [2:0] next_ctrl_term = (ctrl_code == `CTRL_TERM_RESERVED) ?
		`CTRL_TERM_OFF : ctrl_code; // RULE4

	// Clock and chip-select overrides matter only on a non-terminating rank
	wire clk_on = i_term_ctl_clock_en &
		~(i_non_terminating_rank & op_copy[`TO_CLOCK_TERM_N]); // RULE6
	wire cs_on  = i_term_ctl_chip_sel_en &
		~(i_non_terminating_rank & op_copy[`TO_CHIP_SEL_TERM_N]); // RULE7
	wire ca_on  = i_term_ctl_command_en &
		~op_copy[`TO_COMMAND_TERM_D]; // RULE8

	// Byte disables cut all three termination kinds per byte
	wire [1:0] next_clock_term;
	wire [1:0] next_chip_sel_term;
	wire [1:0] next_command_term;
	genvar b;
	generate
		for (b = 0; b < 2; b = b + 1) begin : g_byte
			assign next_clock_term[b]    = clk_on & ~byte_dis[b]; // RULE9
			assign next_chip_sel_term[b] = cs_on & ~byte_dis[b]; // RULE9
			assign next_command_term[b]  = ca_on & ~byte_dis[b]; // RULE9
		end
	endgenerate

	// Bus inversion held off while the calibration pattern is out
	wire next_inversion_active =
		i_data_bus_inversion_en & ~i_cal_active; // RULE3

	// Output flops; the inversion flag lines up with the pattern lanes
	reg [2:0] ctrl_term_value;
	reg [1:0] clock_term;
	reg [1:0] chip_sel_term;
	reg [1:0] command_term;
	reg       inversion_active;
	always @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_term_value  <= `CTRL_TERM_OFF;
			clock_term       <= 2'h0;
			chip_sel_term    <= 2'h0;
			command_term     <= 2'h0;
			inversion_active <= 1'b0;
		end else begin
			ctrl_term_value  <= next_ctrl_term; // RULE4
			clock_term       <= next_clock_term; // RULE6
			chip_sel_term    <= next_chip_sel_term; // RULE7
			command_term     <= next_command_term; // RULE8
			inversion_active <= next_inversion_active; // RULE3
		end
	end

	// Outputs straight from the flops
	assign o_controller_termination_value = ctrl_term_value;
	assign o_clock_term_on                = clock_term;
	assign o_chip_sel_term_on             = chip_sel_term;
	assign o_command_term_on              = command_term;
	assign o_data_bus_inversion_active    = inversion_active;

	// Run-time setting drives the interval timer
	dqs_interval_timer u_timer (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_start    (i_timer_start),
		.i_stop     (i_timer_stop), // RULE16
		.i_run_time (dqs_timer_run_time), // RULE14
		.o_running  (o_timer_running),
		.o_elapsed  (o_timer_elapsed)
	);

endmodule
`default_nettype wire

// *** dv/mr_ctrl_model.sv ***
// Purpose: Controller model issuing mode-register writes and reads
// Assumes: Strobes change at the falling clock edge
// Notes:   Released address and data lines show inverted values
`timescale 1ns/100ps
`default_nettype none
module mr_ctrl_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid,
	output var  logic       o_wr,
	output var  logic       o_rd,
	output var  logic [5:0] o_addr,
	output var  logic [7:0] o_wdata
);
	// Idle bus
	initial begin
		{o_wr, o_rd, o_addr, o_wdata} = 16'h0000;
	end
	// One-cycle write strobe, then lines released
	task automatic mrw(input logic [5:0] a, input logic [7:0] d);
		@(negedge i_clk);
		{o_addr, o_wdata, o_wr} = {a, d, 1'b1};
		@(negedge i_clk);
		{o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0};
	endtask
	// Read strobe, answer taken while valid stands
	task automatic mrr(input logic [5:0] a, output logic [8:0] d);
		@(negedge i_clk);
		{o_addr, o_rd} = {a, 1'b1};
		@(negedge i_clk);
		{o_addr, o_rd} = {~a, 1'b0};
		d = {i_rvalid, i_rdata};
	endtask
endmodule
`default_nettype wire

// *** dv/dram_mr_bank_asserts.sv ***
// Purpose: Port-level checks of the mode-register bank
// Assumes: Bound to the bank top
// Notes:   All checks on i_clk, off during reset
`timescale 1ns/100ps
`default_nettype none
module dram_mr_bank_asserts (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_mr_read,
	input wire logic [5:0]  i_mr_addr,
	input wire logic [7:0]  o_mr_rdata,
	input wire logic        o_mr_rvalid,
	input wire logic        i_data_bus_inversion_en,
	input wire logic        i_cal_active,
	input wire logic        i_cal_bit,
	input wire logic        o_cal_upper_mask_lane,
	input wire logic        o_data_bus_inversion_active,
	input wire logic [2:0]  o_controller_termination_value,
	input wire logic        i_term_ctl_command_en,
	input wire logic [1:0]  o_command_term_on,
	input wire logic        i_timer_start,
	input wire logic        o_timer_running,
	input wire logic [15:0] o_timer_elapsed
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Register port answers
	a_rvalid_after_read: assert property (!$past(i_rst) |->
		o_mr_rvalid == $past(i_mr_read)) else $error("bad rvalid");
	a_unread_zero: assert property (i_mr_read && i_mr_addr != 6'h16
		|=> o_mr_rdata == 8'h00) else $error("bad read data");
	// Calibration path
	a_mask_lane_true: assert property (!$past(i_rst) |->
		o_cal_upper_mask_lane == $past(i_cal_bit)) else $error("mask lane");
	a_inversion_blocked: assert property (!$past(i_rst) |->
		o_data_bus_inversion_active == ($past(i_data_bus_inversion_en)
		&& !$past(i_cal_active))) else $error("bus inversion flag");
	// Termination outputs
	a_ctv_no_rsvd: assert property (
		o_controller_termination_value != 3'h7) else $error("ctv code");
	a_cmd_term_gated: assert property ((o_command_term_on &
		~{2{$past(i_term_ctl_command_en)}}) == 2'b00)
		else $error("cmd term");
	// Timer
	a_timer_start: assert property (i_timer_start |=> o_timer_running
		&& o_timer_elapsed == 16'h0000) else $error("timer start");
	a_timer_step: assert property (o_timer_running &&
		$past(o_timer_running) && !$past(i_timer_start) |-> o_timer_elapsed
		== $past(o_timer_elapsed) + 16'h0001) else $error("timer step");
endmodule
bind dram_mr_bank dram_mr_bank_asserts u_chk (.i_clk, .i_rst, .i_mr_read,
	.i_mr_addr, .o_mr_rdata, .o_mr_rvalid, .i_data_bus_inversion_en,
	.i_cal_active, .i_cal_bit, .o_cal_upper_mask_lane,
	.o_data_bus_inversion_active, .o_controller_termination_value,
	.i_term_ctl_command_en, .o_command_term_on, .i_timer_start,
	.o_timer_running, .o_timer_elapsed);
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the mode-register bank
// Assumes: Inputs change at the falling clock edge
// Notes:   Row table covers register access, hand tests the rest
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        i_clk, i_rst, wr_sel, op_sel, inv_en, ctl_en, byte_mode;
	logic        nt_rank, cal_act, cal_bit, t_start, t_stop, wr, rd;
	logic        rvalid, mask, inv_act, t_run;
	logic [5:0]  addr;
	logic [7:0]  wdata, rdata, dq;
	logic [2:0]  ctv;
	logic [1:0]  ck_on, cs_on, ca_on;
	logic [15:0] t_el;
	logic [8:0]  rd9;
	int          n_fail = 0, checks_done = 0, cyc = 0, w;
	logic [31:0] rows [6] = '{32'h0162A12A, 32'h11654154, 32'h01415100,
		32'h015FF100, 32'h01701100, 32'h03FAA100};
	logic [7:0]  codes [4] = '{8'h01, 8'h3F, 8'h40, 8'h80};
	logic [15:0] lims [4] = '{16'h0010, 16'h03F0, 16'h0800, 16'h1000};
	dram_mr_bank dut (.i_clk(i_clk), .i_rst(i_rst), .i_mr_write(wr),
		.i_mr_read(rd), .i_mr_addr(addr), .i_mr_wdata(wdata),
		.o_mr_rdata(rdata), .o_mr_rvalid(rvalid),
		.i_write_set_point_select(wr_sel),
		.i_operating_set_point_select(op_sel),
		.i_data_bus_inversion_en(inv_en), .i_term_ctl_command_en(ctl_en),
		.i_term_ctl_chip_sel_en(ctl_en), .i_term_ctl_clock_en(ctl_en),
		.i_byte_mode(byte_mode), .i_non_terminating_rank(nt_rank),
		.i_cal_active(cal_act), .i_cal_bit(cal_bit), .o_cal_upper_dq(dq),
		.o_cal_upper_mask_lane(mask), .o_data_bus_inversion_active(inv_act),
		.o_controller_termination_value(ctv), .o_clock_term_on(ck_on),
		.o_chip_sel_term_on(cs_on), .o_command_term_on(ca_on),
		.i_timer_start(t_start), .i_timer_stop(t_stop),
		.o_timer_running(t_run), .o_timer_elapsed(t_el));
	mr_ctrl_model ctl (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	// Compare and count
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Termination outputs after inputs settle
	task automatic trm(input logic [8:0] e);
		@(negedge i_clk);
		chk(16'({ctv, ck_on, cs_on, ca_on}), 16'(e));
	endtask
	task automatic print_verdict;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Clock and hang guard
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict;
		end
	end
	// Test sequence
	initial begin
		{i_rst, wr_sel, op_sel, inv_en, ctl_en, byte_mode} = 6'b100000;
		{nt_rank, cal_act, cal_bit, t_start, t_stop} = 5'b10000;
		repeat (8) @(negedge i_clk);
		i_rst = 1'b0;
		ctl.mrr(6'h16, rd9);
		chk(16'(rd9), 16'h0100);
		$display("reset test done");
		foreach (rows[k]) begin
			wr_sel = rows[k][28];
			ctl.mrw(rows[k][25:20], rows[k][19:12]);
			ctl.mrr(rows[k][25:20], rd9);
			chk(16'(rd9), 16'(rows[k][8:0]));
		end
		$display("row test done");
		ctl_en = 1'b1;
		wr_sel = 1'b0;
		ctl.mrr(6'h16, rd9);
		chk(16'(rd9), 16'h012A);
		trm(9'h08C);
		op_sel = 1'b1;
		trm(9'h133);
		byte_mode = 1'b1;
		trm(9'h122);
		nt_rank = 1'b0;
		trm(9'h12A);
		{byte_mode, nt_rank, wr_sel} = 3'b011;
		ctl.mrw(6'h16, 8'h07);
		trm(9'h03F);
		wr_sel = 1'b0;
		ctl.mrw(6'h16, 8'hFF);
		trm(9'h03F);
		wr_sel = 1'b1;
		ctl.mrr(6'h16, rd9);
		chk(16'(rd9), 16'h0107);
		ctl_en = 1'b0;
		trm(9'h000);
		$display("termination test done");
		ctl.mrw(6'h14, 8'h15);
		{cal_act, inv_en, cal_bit} = 3'b111;
		@(negedge i_clk);
		chk(16'({dq, mask, inv_act}), 16'h03AA);
		cal_bit = 1'b0;
		@(negedge i_clk);
		chk(16'({dq, mask, inv_act}), 16'h0054);
		cal_act = 1'b0;
		@(negedge i_clk);
		chk(16'({dq, mask, inv_act}), 16'h0055);
		$display("calibration test done");
		for (int k = 0; k < 4; k++) begin
			ctl.mrw(6'h17, codes[k]);
			t_start = 1'b1;
			@(negedge i_clk);
			t_start = 1'b0;
			for (w = 0; w < 5000 && t_run !== 1'b0; w++)
				@(negedge i_clk);
			chk({t_el[15:8], t_el[7:0]}, lims[k]);
		end
		ctl.mrw(6'h17, 8'h00);
		t_start = 1'b1;
		@(negedge i_clk);
		t_start = 1'b0;
		repeat (4200) @(negedge i_clk);
		chk(16'(t_run), 16'h0001);
		t_stop = 1'b1;
		@(negedge i_clk);
		t_stop = 1'b0;
		chk(16'(t_run), 16'h0000);
		$display("timer test done");
		print_verdict;
	end
endmodule
`default_nettype wire
